// file: logic/arith_coprocessor.v
// Unsigned multiply, divide, shift and normalize coprocessor on the SFR bus
`timescale 1ns/1ps
`include "arith_coprocessor_defs.vh"

module arith_coprocessor (
  input  wire       I_SYS_CLK,
  input  wire       I_RST,
  input  wire [7:0] I_SFR_ADDR,
  input  wire       I_SFR_WR,
  input  wire [7:0] I_SFR_WDATA,
  input  wire       I_SFR_RD,
  input  wire       I_ERR_ON_READ_EN,
  output reg  [7:0] O_SFR_RDATA,
  output reg        O_BUSY
);

  // Operand bytes 0..5 packed, byte 0 in the low bits
  reg  [47:0] opd_q;
  reg  [47:0] opd_d;
  reg  [2:0]  op_q;
  reg  [2:0]  op_d;
  reg  [4:0]  sc_q;
  reg  [4:0]  sc_d;
  reg  [3:0]  cnt_q;
  reg  [3:0]  cnt_d;
  reg         busy_q;
  reg         busy_d;
  reg         err_q;
  reg         err_d;
  reg         ovf_q;
  reg         ovf_d;
  reg  [4:0]  ncnt_q;
  reg  [4:0]  ncnt_d;
  reg  [7:0]  rdata_d;

  // Results of the selected operation, valid at completion
  reg  [47:0] res_opd;
  reg         res_ovf;
  reg  [4:0]  res_ncnt;

  // Datapath views and arithmetic results
  wire [31:0] val32;
  wire [15:0] lo16;
  wire [15:0] den16;
  wire [31:0] dvd_sel;
  wire [31:0] quo;
  wire [15:0] rem16;
  wire        div_zero;
  wire [31:0] product;
  wire [4:0]  lz_cnt;

  // Bus decode
  wire        ctl_wr;
  wire        opd_wr;
  wire        opd_rd;
  wire [2:0]  wr_op;
  wire [4:0]  wr_sc;
  wire        wr_start;
  wire        finish;

  // True for any of the six operand byte addresses
  function is_operand;
    input [7:0] addr;
    begin
      is_operand = (addr >= `ADDR_OPERAND_BYTE0) && (addr <= `ADDR_OPERAND_BYTE5);
    end
  endfunction

  // Opcodes that start work; everything else is idle
  function is_active_op;
    input [2:0] op;
    begin
      is_active_op = (op >= `OP_DIV32) && (op <= `OP_NORM);
    end
  endfunction

  // Fixed execution length of each opcode
  function [3:0] op_cycles;
    input [2:0] op;
    begin
      if ((op == `OP_SHL) || (op == `OP_SHR) || (op == `OP_NORM)) begin
        op_cycles = `CYC_SHIFT_NORM;
      end else begin
        op_cycles = `CYC_DIV_MUL;
      end
    end
  endfunction

  // Leading zero count of a 32-bit word; zero input counts as none
  function [4:0] lead_zeros;
    input [31:0] v;
    integer k;
    integer t;
    reg     seen;
    begin
      lead_zeros = 5'h00;
      seen       = 1'b0;
      for (k = 31; k >= 0; k = k - 1) begin
        if (!seen && v[k]) begin
          seen       = 1'b1;
          t          = 31 - k;
          lead_zeros = t[4:0];
        end
      end
    end
  endfunction

  // Byte index of an operand address
  function [2:0] byte_index;
    input [7:0] addr;
    reg   [7:0] diff;
    begin
      diff       = addr - `ADDR_OPERAND_BYTE0;
      byte_index = diff[2:0];
    end
  endfunction

  // Bus decode; the SFR bus runs on this clock, so no synchronisers
  // A write and a read in one cycle both act; the read sees the old value
  assign ctl_wr   = I_SFR_WR && (I_SFR_ADDR == `ADDR_ARITH_CONTROL);
  assign opd_wr   = I_SFR_WR && is_operand(I_SFR_ADDR);
  assign opd_rd   = I_SFR_RD && is_operand(I_SFR_ADDR);
  assign wr_op    = I_SFR_WDATA[`CTL_OPCODE_MSB:`CTL_OPCODE_LSB];
  assign wr_sc    = I_SFR_WDATA[`CTL_SC_MSB:`CTL_SC_LSB];
  assign wr_start = ctl_wr && is_active_op(wr_op);
  assign finish   = busy_q && (cnt_q == 4'h0);

  // Operand views, least significant byte at the lowest address
  assign val32   = opd_q[31:0];
  assign lo16    = opd_q[15:0];
  assign den16   = opd_q[47:32];
  assign dvd_sel = (op_q == `OP_DIV16) ? {16'h0000, lo16} : val32;

  // Plain unsigned arithmetic; no sign handling anywhere
  assign product = lo16 * den16;
  assign lz_cnt  = lead_zeros(val32);

  arith_divider #(
    .NUM_W (32),
    .DEN_W (16)
  ) u_div (
    .i_dividend  (dvd_sel),
    .i_divisor   (den16),
    .o_quotient  (quo),
    .o_remainder (rem16),
    .o_div_zero  (div_zero)
  );

  // Result selection. Results are evaluated from the live operands at
  // the end; any operand write restarts the count, so they are stable.
  // A zero divisor leaves every operand as it was, so software can retry.
  always @* begin
    res_opd  = opd_q;
    res_ovf  = 1'b0;
    res_ncnt = ncnt_q;
    case (op_q)
      `OP_DIV32: begin
        if (div_zero) begin
          res_ovf = 1'b1;
        end else begin
          res_opd = {rem16, quo};
        end
      end
      `OP_DIV16: begin
        if (div_zero) begin
          res_ovf = 1'b1;
        end else begin
          res_opd = {rem16, opd_q[31:16], quo[15:0]};
        end
      end
      `OP_MUL16: begin
        res_opd = {opd_q[47:32], product};
        res_ovf = (product > `MUL_LIMIT);
      end
      `OP_SHL: begin
        res_opd = {opd_q[47:32], val32 << sc_q};
      end
      `OP_SHR: begin
        res_opd = {opd_q[47:32], val32 >> sc_q};
      end
      `OP_NORM: begin
        // An all-zero word has no top bit to find and is left as is
        res_opd  = {opd_q[47:32], val32 << lz_cnt};
        res_ncnt = lz_cnt;
        res_ovf  = val32[31];
      end
      default: begin
        res_opd = opd_q;
      end
    endcase
  end

  // Sequencing and flag update. Later statements override earlier ones,
  // so the order is finish, operand write, read error, control write;
  // a control write therefore decides what happens on a colliding edge.
  always @* begin
    opd_d  = opd_q;
    op_d   = op_q;
    sc_d   = sc_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    err_d  = err_q;
    ovf_d  = ovf_q;
    ncnt_d = ncnt_q;

    // Countdown runs on its own; the processor keeps executing meanwhile
    // The count reaches zero on the last computing cycle, which is finish
    if (busy_q && (cnt_q != 4'h0)) begin
      cnt_d = cnt_q - 4'h1;
    end

    // Completion writes results over the operands and raises done
    if (finish) begin
      opd_d  = res_opd;
      busy_d = 1'b0;
      ncnt_d = res_ncnt;
      // Overflow is only ever set here; software and starts clear it
      if (res_ovf) begin
        ovf_d = 1'b1;
      end
    end

    // An operand byte write during computing restarts the count. The
    // restart works on the operands as they stood, so a write that meets
    // the finishing edge drops the old result, its overflow and its count.
    if (opd_wr) begin
      if (busy_q) begin
        opd_d  = opd_q;
        ovf_d  = ovf_q;
        ncnt_d = ncnt_q;
        busy_d = 1'b1;
        cnt_d  = op_cycles(op_q) - 4'h1;
        err_d  = 1'b1;
      end
      case (byte_index(I_SFR_ADDR))
        3'h0: opd_d[7:0]   = I_SFR_WDATA;
        3'h1: opd_d[15:8]  = I_SFR_WDATA;
        3'h2: opd_d[23:16] = I_SFR_WDATA;
        3'h3: opd_d[31:24] = I_SFR_WDATA;
        3'h4: opd_d[39:32] = I_SFR_WDATA;
        default: opd_d[47:40] = I_SFR_WDATA;
      endcase
    end

    // Enabled reads during computing only flag the error
    if (opd_rd && busy_q && I_ERR_ON_READ_EN) begin
      err_d = 1'b1;
    end

    // Control writes: a real opcode starts; idle clears overflow and aborts any run
    if (ctl_wr) begin
      op_d = wr_op;
      sc_d = wr_sc;
      if (wr_start) begin
        busy_d = 1'b1;
        cnt_d  = op_cycles(wr_op) - 4'h1;
        ovf_d  = 1'b0;
        // Set wins: a start that interrupts a running op is an error
        err_d  = busy_q;
        if (busy_q) begin
          // A colliding finish must not leave its result or count behind
          opd_d  = opd_q;
          ncnt_d = ncnt_q;
        end
      end else begin
        ovf_d = 1'b0;
        if (busy_q) begin
          // Idle opcode aborts the run and leaves operands untouched
          busy_d = 1'b0;
          err_d  = 1'b1;
          opd_d  = opd_q;
          ncnt_d = ncnt_q;
        end
      end
    end
  end

  // Read data is captured at the read strobe and held until the next one
  always @* begin
    rdata_d = O_SFR_RDATA;
    if (I_SFR_RD) begin
      case (I_SFR_ADDR)
        `ADDR_OPERAND_BYTE0: rdata_d = opd_q[7:0];
        `ADDR_OPERAND_BYTE1: rdata_d = opd_q[15:8];
        `ADDR_OPERAND_BYTE2: rdata_d = opd_q[23:16];
        `ADDR_OPERAND_BYTE3: rdata_d = opd_q[31:24];
        `ADDR_OPERAND_BYTE4: rdata_d = opd_q[39:32];
        `ADDR_OPERAND_BYTE5: rdata_d = opd_q[47:40];
        `ADDR_ARITH_CONTROL: rdata_d = {err_q, ovf_q, ~busy_q, ncnt_q};
        default:             rdata_d = `UNMAPPED_RDATA;
      endcase
    end
  end

  // State registers; done reads one from reset because busy is clear
  // O_BUSY takes the next busy value so it leaves a flip-flop yet
  // always matches busy_q
  always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      opd_q       <= `RST_OPERAND;
      op_q        <= 3'h0;
      sc_q        <= 5'h00;
      cnt_q       <= 4'h0;
      busy_q      <= 1'b0;
      err_q       <= 1'b0;
      ovf_q       <= 1'b0;
      ncnt_q      <= `RST_NCNT;
      O_SFR_RDATA <= `RST_RDATA;
      O_BUSY      <= 1'b0;
    end else begin
      opd_q       <= opd_d;
      op_q        <= op_d;
      sc_q        <= sc_d;
      cnt_q       <= cnt_d;
      busy_q      <= busy_d;
      err_q       <= err_d;
      ovf_q       <= ovf_d;
      ncnt_q      <= ncnt_d;
      O_SFR_RDATA <= rdata_d;
      O_BUSY      <= busy_d;
    end
  end

endmodule // arith_coprocessor

// file: logic/arith_coprocessor_defs.vh
// Constants for the unsigned multiply, divide and shift coprocessor
`ifndef ARITH_COPROCESSOR_DEFS_VH
`define ARITH_COPROCESSOR_DEFS_VH

// Special-function-register addresses
`define ADDR_OPERAND_BYTE0   8'hf1
`define ADDR_OPERAND_BYTE1   8'hf2
`define ADDR_OPERAND_BYTE2   8'hf3
`define ADDR_OPERAND_BYTE3   8'hf4
`define ADDR_OPERAND_BYTE4   8'hf5
`define ADDR_OPERAND_BYTE5   8'hf6
`define ADDR_ARITH_CONTROL   8'hf7

// Read view of the control register
`define CTL_ERR_BIT          7
`define CTL_OVF_BIT          6
`define CTL_DONE_BIT         5
`define CTL_NCNT_MSB         4
`define CTL_NCNT_LSB         0

// Write view of the control register
`define CTL_OPCODE_MSB       7
`define CTL_OPCODE_LSB       5
`define CTL_SC_MSB           4
`define CTL_SC_LSB           0

// Opcodes; any other value leaves the unit idle
`define OP_DIV32             3'h1
`define OP_MUL16             3'h2
`define OP_DIV16             3'h3
`define OP_SHL               3'h4
`define OP_SHR               3'h5
`define OP_NORM              3'h6

// Execution times in processor clock cycles
`define CYC_DIV_MUL          4'h9
`define CYC_SHIFT_NORM       4'h7

// Reset values and the read data of unmapped addresses
`define RST_OPERAND          48'h0000_0000_0000
`define RST_RDATA            8'h00
`define RST_NCNT             5'h00
`define UNMAPPED_RDATA       8'h00

// Largest 16-bit product that does not overflow
`define MUL_LIMIT            32'h0000_ffff

`endif

// file: logic/arith_divider.v
// Combinational unsigned 32 by 16 restoring divider
`timescale 1ns/1ps

module arith_divider #(
  parameter NUM_W = 32,
  parameter DEN_W = 16
) (
  input  wire [NUM_W-1:0] i_dividend,
  input  wire [DEN_W-1:0] i_divisor,
  output reg  [NUM_W-1:0] o_quotient,
  output reg  [DEN_W-1:0] o_remainder,
  output wire             o_div_zero
);

  reg [DEN_W:0] part;
  integer       i;

  // Divisor zero is flagged separately; the caller keeps its operands then
  assign o_div_zero = (i_divisor == {DEN_W{1'b0}});

  // One restoring step per dividend bit, most significant first
  always @* begin
    part        = {(DEN_W+1){1'b0}};
    o_quotient  = {NUM_W{1'b0}};
    o_remainder = {DEN_W{1'b0}};
    for (i = NUM_W - 1; i >= 0; i = i - 1) begin
      part = {part[DEN_W-1:0], i_dividend[i]};
      if (part >= {1'b0, i_divisor}) begin
        part          = part - {1'b0, i_divisor};
        o_quotient[i] = 1'b1;
      end
    end
    o_remainder = part[DEN_W-1:0];
  end

endmodule // arith_divider

// file: testbench/arith_coprocessor_chk.sv
// Port-level assertions for the arith coprocessor
`timescale 1ns/1ps

module arith_coprocessor_chk (
  input wire        I_SYS_CLK,
  input wire        I_RST,
  input wire  [7:0] I_SFR_ADDR,
  input wire        I_SFR_WR,
  input wire  [7:0] I_SFR_WDATA,
  input wire        I_SFR_RD,
  input wire        I_ERR_ON_READ_EN,
  input logic [7:0] O_SFR_RDATA,
  input logic       O_BUSY
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  // Decoded bus events; a read paired with a write is left out
  wire [2:0] op     = I_SFR_WDATA[7:5];
  wire       ctl_wr = I_SFR_WR && I_SFR_ADDR == 8'hf7;
  wire       ctl_rd = I_SFR_RD && !I_SFR_WR && I_SFR_ADDR == 8'hf7;
  wire       opd    = I_SFR_ADDR >= 8'hf1 && I_SFR_ADDR <= 8'hf6;
  wire       run    = ctl_wr && op >= 3'h1 && op <= 3'h6;

  // Steps: a start from idle, then a quiet cycle and a control read
  sequence s_start;
    !O_BUSY && run;
  endsequence
  sequence s_ctl_read;
    !I_SFR_WR && !I_SFR_RD ##1 ctl_rd;
  endsequence

  // Cycles since a start from idle with no bus write since; a long opcode
  // is remembered so one small counter serves the nine-cycle check
  logic [3:0] run_len  = 4'h0;
  logic       run_long = 1'b0;
  always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      run_len  <= 4'h0;
      run_long <= 1'b0;
    end else if (!O_BUSY && run) begin
      run_len  <= 4'h1;
      run_long <= (op <= 3'h3);
    end else if (I_SFR_WR) begin
      run_len <= 4'h0;
    end else if (run_len != 4'h0 && run_len != 4'hf) begin
      run_len <= run_len + 4'h1;
    end
  end

  chk_reset_idle: assert property ($fell(I_RST) |-> !O_BUSY && O_SFR_RDATA == 8'h00)
    else $error("not idle after reset");
  chk_start_busy: assert property (run |=> O_BUSY)
    else $error("no busy after start");
  chk_idle_opcode: assert property (!O_BUSY && ctl_wr && !run |=> !O_BUSY)
    else $error("idle opcode started");
  chk_long_time: assert property (run_long && run_len == 4'h9 && !I_SFR_WR |-> O_BUSY ##1 !O_BUSY)
    else $error("long run time wrong");
  chk_short_time: assert property (s_start ##0 (op >= 3'h4) ##1 (!I_SFR_WR)[*7] |-> O_BUSY ##1 !O_BUSY)
    else $error("short run time wrong");
  chk_write_error: assert property (O_BUSY && I_SFR_WR && opd ##1 s_ctl_read |=> O_SFR_RDATA[7])
    else $error("busy write left error clear");
  chk_read_error: assert property (O_BUSY && I_ERR_ON_READ_EN && I_SFR_RD && opd ##1 s_ctl_read |=> O_SFR_RDATA[7])
    else $error("busy read left error clear");
  chk_start_clear: assert property (s_start ##1 s_ctl_read |=> O_SFR_RDATA[7:5] == 3'b000)
    else $error("start left flags set");
  chk_done_bit: assert property (ctl_rd |=> O_SFR_RDATA[5] == !$past(O_BUSY))
    else $error("done bit wrong");
endmodule // arith_coprocessor_chk

bind arith_coprocessor arith_coprocessor_chk i_arith_coprocessor_chk (
  .I_SYS_CLK        (I_SYS_CLK),
  .I_RST            (I_RST),
  .I_SFR_ADDR       (I_SFR_ADDR),
  .I_SFR_WR         (I_SFR_WR),
  .I_SFR_WDATA      (I_SFR_WDATA),
  .I_SFR_RD         (I_SFR_RD),
  .I_ERR_ON_READ_EN (I_ERR_ON_READ_EN),
  .O_SFR_RDATA      (O_SFR_RDATA),
  .O_BUSY           (O_BUSY)
);

// file: testbench/sfr_master.sv
// Processor-side register bus master model
`timescale 1ns/1ps

module sfr_master (
  input  wire       i_clk,
  input  wire [7:0] i_rdata,
  output logic [7:0] o_addr  = 8'h00,
  output logic       o_wr    = 1'b0,
  output logic [7:0] o_wdata = 8'h00,
  output logic       o_rd    = 1'b0
);
  // One access at a time: the unit has a single context
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
    @(posedge i_clk);
    #1;
    o_addr  = a;
    o_wdata = d;
    o_wr    = w;
    o_rd    = !w;
    @(posedge i_clk);
    #1;
    v       = i_rdata;
    // Released lines carry the inverse so stale values never pass
    o_addr  = ~a;
    o_wdata = ~d;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  endtask
endmodule // sfr_master

// file: testbench/testbench.sv
// Self-checking bench for the arith coprocessor
`timescale 1ns/1ps

module testbench;
  logic       clk    = 1'b0;
  logic       rst    = 1'b1;
  logic       err_en = 1'b0;
  logic       wr;
  logic       rd;
  logic       busy;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [4:0] ncnt = 5'h00;
  int         mismatches = 0;
  int         samples_checked = 0;

  always #2.5 clk = ~clk;

  arith_coprocessor i_arith_coprocessor (
    .I_SYS_CLK        (clk),
    .I_RST            (rst),
    .I_SFR_ADDR       (addr),
    .I_SFR_WR         (wr),
    .I_SFR_WDATA      (wdata),
    .I_SFR_RD         (rd),
    .I_ERR_ON_READ_EN (err_en),
    .O_SFR_RDATA      (rdata),
    .O_BUSY           (busy)
  );

  sfr_master i_sfr_master (
    .i_clk   (clk),
    .i_rdata (rdata),
    .o_addr  (addr),
    .o_wr    (wr),
    .o_wdata (wdata),
    .o_rd    (rd)
  );

  task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task w(input logic [7:0] a, input logic [7:0] d);
    i_sfr_master.acc(1'b1, a, d, v);
  endtask

  task r(input logic [7:0] a);
    i_sfr_master.acc(1'b0, a, 8'h00, v);
  endtask

  // Bounded wait; counts edges until busy falls
  task wait_idle(output logic [7:0] n);
    n = 8'h00;
    while (busy !== 1'b0 && n < 8'h40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Unmapped address f0 first, then every register
  task t_reset;
    for (int i = 0; i < 8; i++) begin
      r(8'hf0 + i[7:0]);
      chk8("reset read", i == 7 ? 8'h20 : 8'h00, v);
    end
  endtask

  // Load, run one opcode, then compare all six bytes and the flags
  task do_op(input logic [2:0] op, input logic [4:0] sc, input logic [31:0] a, input logic [15:0] b);
    logic [47:0] e;
    logic [47:0] s;
    logic        ov;
    logic [7:0]  n;
    s = {b, a};
    e = s;
    ov = 1'b0;
    case (op)
      3'h1: if (b == 16'h0000)
          ov = 1'b1;
        else
          e = {16'(a % b), a / b};
      3'h2: begin
        e[31:0] = a[15:0] * b;
        ov = e[31:0] > 32'h0000ffff;
      end
      3'h3: if (b == 16'h0000)
          ov = 1'b1;
        else
          e = {16'(a[15:0] % b), a[31:16], 16'(a[15:0] / b)};
      3'h4: e[31:0] = a << sc;
      3'h5: e[31:0] = a >> sc;
      default: begin
        ov = a[31];
        ncnt = 5'h00;
        // Model leading-zero removal; zero stays zero
        while (e[31:0] != 0 && !e[31]) begin
          e[31:0] = e[31:0] << 1;
          ncnt++;
        end
      end
    endcase
    for (int i = 0; i < 6; i++)
      w(8'hf1 + i[7:0], s[8*i +: 8]);
    w(8'hf7, {op, sc});
    wait_idle(n);
    chk8("op cycles", op < 3'h4 ? 8'h09 : 8'h07, n);
    for (int i = 0; i < 6; i++) begin
      r(8'hf1 + i[7:0]);
      chk8("result byte", e[8*i +: 8], v);
    end
    r(8'hf7);
    chk8("control", {1'b0, ov, 1'b1, ncnt}, v);
  endtask

  // Every opcode, with zero divisors and overflow boundaries
  task t_ops;
    do_op(3'h1, 5'h00, 32'h1234_5678, 16'h1234);
    do_op(3'h1, 5'h00, 32'hffff_ffff, 16'h0001);
    do_op(3'h1, 5'h00, 32'h0000_1000, 16'h0000);
    do_op(3'h2, 5'h00, 32'h0000_ffff, 16'hffff);
    do_op(3'h2, 5'h00, 32'h0000_00ff, 16'h0101);
    do_op(3'h3, 5'h00, 32'habcd_1234, 16'h0033);
    do_op(3'h3, 5'h00, 32'h0000_0005, 16'h0000);
    do_op(3'h4, 5'h1f, 32'h8000_0003, 16'h0001);
    do_op(3'h5, 5'h04, 32'h8000_0003, 16'h0001);
    do_op(3'h6, 5'h00, 32'h0d01_0307, 16'h0001);
    do_op(3'h6, 5'h00, 32'h8000_0000, 16'h0001);
    do_op(3'h6, 5'h00, 32'h0000_0001, 16'h0001);
  endtask

  // Idle opcodes start nothing; writing one clears overflow
  task t_idle;
    do_op(3'h1, 5'h00, 32'h0000_1000, 16'h0000);
    w(8'hf7, 8'h00);
    r(8'hf7);
    chk8("ovf clear", {3'b001, ncnt}, v);
    w(8'hf7, 8'hff);
    chk8("idle busy", 8'h00, {7'h00, busy});
  endtask

  // Operand write mid-run flags an error; the next start clears it
  task t_err_wr;
    logic [7:0] n;
    w(8'hf7, 8'h40);
    r(8'hf7);
    chk8("started", {3'b000, ncnt}, v);
    w(8'hf3, 8'h55);
    r(8'hf7);
    chk8("write error", {3'b100, ncnt}, v);
    wait_idle(n);
    do_op(3'h2, 5'h00, 32'h0000_0101, 16'h00ff);
  endtask

  // Mid-run reads flag an error only when enabled; run time is kept
  task t_err_rd;
    logic [7:0] n;
    for (int k = 0; k < 2; k++) begin
      err_en = k[0];
      w(8'hf7, 8'h20);
      r(8'hf1);
      r(8'hf7);
      chk8("read error", {k[0], 2'b00, ncnt}, v);
      wait_idle(n);
      chk8("read run time", 8'h05, n);
    end
    err_en = 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_ops;
    t_idle;
    t_err_wr;
    t_err_rd;
    summarize;
  end

  // The run needs under 600 cycles; this cuts a hang short
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule // testbench
